/* src/udc_regs.svh */
// Register map, field positions and reset values of the up/down counter block
`ifndef UDC_REGS_SVH
`define UDC_REGS_SVH

`define UDC_ADDR_W         8
`define UDC_CTRL_OFS       8'h00
`define UDC_STATUS_OFS     8'h04
`define UDC_IRQ_STAT_OFS   8'h08
`define UDC_IRQ_MASK_OFS   8'h0C

`define UDC_CTRL_HOLD_BIT  0
`define UDC_ST_TC_BIT      16
`define UDC_ST_DOWN_BIT    17
`define UDC_ST_LOAD_BIT    18

`define UDC_IRQ_W          2
`define UDC_IRQ_WRAP_BIT   0
`define UDC_IRQ_LOAD_BIT   1

`define UDC_CTRL_RST       1'h0
`define UDC_IRQ_RST        2'h0
`define UDC_MASK_RST       2'h0
`define UDC_COUNT_RST      4'h0
`define UDC_MAX_W          16

`endif

/* src/udc_pkg.sv */
// Types shared by the up/down counter block
package udc_pkg;
   typedef struct packed {
      logic       load_n;
      logic [3:0] preset;
      logic       enable_n;
      logic       down;
      logic       clk;
   } udc_pins_in_t;

   typedef struct packed {
      logic [3:0] count;
      logic       tc;
      logic       ripple_n;
   } udc_pins_out_t;

   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } udc_apb_req_t;
endpackage

/* src/udc_counter.sv */
// Presettable 4-bit up/down counter with terminal count, ripple clock and APB registers
`include "udc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module udc_counter #(
   parameter int WIDTH = 4
) (
   input  wire logic                  CLK_SYS,
   input  wire logic                  RESET_N,
   input  wire udc_pkg::udc_pins_in_t PINS,
   output var  udc_pkg::udc_pins_out_t PINS_OUT,
   input  wire udc_pkg::udc_apb_req_t APB,
   output logic [31:0]                PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   output logic                       IRQ
);
   import udc_pkg::*;

   // The count, decode and status layout are built for exactly four bits
   if (WIDTH != 4) begin : g_width_check
      $error("udc_counter serves a 4-bit count only");
   end

   localparam logic [3:0] ALL_ONES = 4'hF;
   localparam logic [3:0] ZERO     = 4'h0;

   logic [3:0]           count;
   logic [3:0]           next_count;
   logic                 clk_prev;
   logic                 hold;
   logic                 next_hold;
   logic [`UDC_IRQ_W-1:0] irq_stat;
   logic [`UDC_IRQ_W-1:0] next_irq_stat;
   logic [`UDC_IRQ_W-1:0] irq_mask;
   logic [`UDC_IRQ_W-1:0] next_irq_mask;
   logic [3:0]           shown;
   logic                 loading;
   logic                 enable_n_eff;
   logic                 clk_rise;
   logic                 step;
   logic                 tc;
   logic                 wr;
   logic                 rd;
   logic                 mapped;
   logic [31:0]          next_prdata;

   // Software hold acts exactly like a high pin enable
   assign loading      = !PINS.load_n;
   assign enable_n_eff = PINS.enable_n | hold;
   assign clk_rise     = PINS.clk & !clk_prev;
   assign step         = !loading && !enable_n_eff && clk_rise;

   // Load bypasses the register so the outputs follow the preset at once
   assign shown = loading ? PINS.preset : count;
   assign tc    = PINS.down ? (shown == ZERO) : (shown == ALL_ONES);

   always_comb begin
      next_count = count;
      if (loading) begin
         next_count = PINS.preset;
      end else if (step) begin
         if (PINS.down) begin
            next_count = count - 4'h1;
         end else begin
            next_count = count + 4'h1;
         end
      end
      // with enable high step is low and the count holds
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         count    <= `UDC_COUNT_RST;
         clk_prev <= 1'b1;
      end else begin
         count    <= next_count;
         clk_prev <= PINS.clk;
      end
   end

   always_comb begin
      PINS_OUT.count    = shown;
      PINS_OUT.tc       = tc;
      PINS_OUT.ripple_n = !(tc && !enable_n_eff && !PINS.clk);
   end

   // APB slave: zero wait states, error on unmapped addresses
   assign wr      = APB.psel && APB.penable && APB.pwrite;
   assign rd      = APB.psel && APB.penable && !APB.pwrite;
   assign PREADY  = 1'b1;
   assign mapped  = (APB.paddr == `UDC_CTRL_OFS) || (APB.paddr == `UDC_STATUS_OFS) ||
                    (APB.paddr == `UDC_IRQ_STAT_OFS) || (APB.paddr == `UDC_IRQ_MASK_OFS);
   assign PSLVERR = APB.psel && APB.penable && !mapped;
   assign IRQ     = |(irq_stat & irq_mask);

   always_comb begin
      next_hold     = hold;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      next_prdata   = 32'h0000_0000;
      if (wr && APB.paddr == `UDC_CTRL_OFS) begin
         next_hold = APB.pwdata[`UDC_CTRL_HOLD_BIT];
      end
      if (wr && APB.paddr == `UDC_IRQ_MASK_OFS) begin
         next_irq_mask = APB.pwdata[`UDC_IRQ_W-1:0];
      end
      if (wr && APB.paddr == `UDC_IRQ_STAT_OFS) begin
         next_irq_stat = irq_stat & ~APB.pwdata[`UDC_IRQ_W-1:0];
      end
      // Events are applied after the clear so a coincident set wins
      if (step && tc) begin
         next_irq_stat[`UDC_IRQ_WRAP_BIT] = 1'b1;
      end
      if (loading) begin
         next_irq_stat[`UDC_IRQ_LOAD_BIT] = 1'b1;
      end
      if (rd) begin
         unique case (APB.paddr)
            `UDC_CTRL_OFS: begin
               next_prdata[`UDC_CTRL_HOLD_BIT] = hold;
            end
            `UDC_STATUS_OFS: begin
               next_prdata[3:0]              = shown;
               next_prdata[`UDC_ST_TC_BIT]   = tc;
               next_prdata[`UDC_ST_DOWN_BIT] = PINS.down;
               next_prdata[`UDC_ST_LOAD_BIT] = loading;
            end
            `UDC_IRQ_STAT_OFS: begin
               next_prdata[`UDC_IRQ_W-1:0] = irq_stat;
            end
            `UDC_IRQ_MASK_OFS: begin
               next_prdata[`UDC_IRQ_W-1:0] = irq_mask;
            end
            default: begin
               next_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         hold     <= `UDC_CTRL_RST;
         irq_stat <= `UDC_IRQ_RST;
         irq_mask <= `UDC_MASK_RST;
      end else begin
         hold     <= next_hold;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
      end
   end

   // Read data is combinational from the access phase so it is valid while PREADY is high
   always_comb begin
      PRDATA = next_prdata;
   end

   // All checks below run in the system clock domain and sleep during reset
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);

   // Load and priority

   // Outputs follow the preset in the same cycle as the load
   a_load_copies: assert property (loading |-> PINS_OUT.count == PINS.preset)
      else $error("outputs do not show preset while loading");

   // The register ends up with the preset, never a stepped value
   a_load_priority: assert property (loading |=> count == $past(PINS.preset))
      else $error("count step taken during load");

   // Counting steps

   // Enable high, pin or software hold, freezes the register
   a_hold_enable: assert property (!loading && enable_n_eff |=> count == $past(count))
      else $error("count moved with enable high");

   // Without a rising count clock nothing moves
   a_edge_only: assert property (!loading && !clk_rise |=> count == $past(count))
      else $error("count moved without clock edge");

   // Direction low steps up by one
   a_count_up: assert property (step && !PINS.down |=> count == 4'($past(count) + 4'h1))
      else $error("up step wrong");

   // Direction high steps down by one
   a_count_down: assert property (step && PINS.down |=> count == 4'($past(count) - 4'h1))
      else $error("down step wrong");

   // Fifteen counting up wraps to zero
   a_wrap_up: assert property (step && !PINS.down && count == ALL_ONES |=> count == ZERO)
      else $error("up wrap wrong");

   // Zero counting down wraps to fifteen
   a_wrap_down: assert property (step && PINS.down && count == ZERO |=> count == ALL_ONES)
      else $error("down wrap wrong");

   // Terminal count and ripple clock

   // Decode from the shown count and direction only
   a_tc_decode: assert property (PINS_OUT.tc == (PINS.down ? PINS_OUT.count == ZERO
                                                          : PINS_OUT.count == ALL_ONES))
      else $error("terminal count decode wrong");

   // With no step, load or direction change the flag stays up
   a_tc_stays: assert property (tc && !step && !loading ##1 !loading && $stable(PINS.down)
                                |-> PINS_OUT.tc)
      else $error("terminal count dropped without a state change");

   // A step out of the terminal state drops the flag at that edge
   a_tc_falls: assert property (step && tc ##1 (PINS.down == $past(PINS.down)) && !loading
                                |-> !PINS_OUT.tc)
      else $error("terminal count did not fall after step");

   // Enable does not gate the flag
   a_tc_no_enable: assert property (enable_n_eff && !loading && $stable(PINS.down)
                                    |=> PINS_OUT.tc == $past(PINS_OUT.tc))
      else $error("terminal count moved with enable high");

   // With the flag up and counting on, ripple follows the count clock
   a_ripple_follow: assert property (tc && !enable_n_eff |-> PINS_OUT.ripple_n == PINS.clk)
      else $error("ripple clock does not follow count clock");

   // No ripple pulse outside the terminal state
   a_ripple_idle: assert property (!tc |-> PINS_OUT.ripple_n)
      else $error("ripple pulse without terminal count");

   // Enable high blocks the pulse, which stops a whole cascade
   a_ripple_inhibit: assert property (enable_n_eff |-> PINS_OUT.ripple_n)
      else $error("ripple pulse while inhibited");

   // Register side

   // A step taken in the terminal state raises the wrap flag
   a_irq_wrap_set: assert property (step && tc |=> irq_stat[`UDC_IRQ_WRAP_BIT])
      else $error("wrap event not recorded");

   // Every load cycle raises the load flag
   a_irq_load_set: assert property (loading |=> irq_stat[`UDC_IRQ_LOAD_BIT])
      else $error("load event not recorded");

   // A fully masked block never interrupts
   a_irq_level: assert property (irq_mask == `UDC_MASK_RST |-> !IRQ)
      else $error("interrupt raised while masked");

   // Every access phase completes at once
   a_ready_access: assert property (APB.psel && APB.penable |-> PREADY)
      else $error("access phase without ready");

   // Unmapped addresses answer with an error
   a_slverr_unmapped: assert property (APB.psel && APB.penable && !mapped |-> PSLVERR)
      else $error("unmapped access without error");

   // Control writes land at the access edge
   a_hold_write: assert property (wr && APB.paddr == `UDC_CTRL_OFS
                                  |=> hold == $past(APB.pwdata[`UDC_CTRL_HOLD_BIT]))
      else $error("hold bit write lost");

   // Status read shows the live count
   a_status_read: assert property (rd && APB.paddr == `UDC_STATUS_OFS
                                   |-> PRDATA[3:0] == PINS_OUT.count)
      else $error("status read count wrong");

   // Scenarios worth seeing

   c_up_wrap: cover property (step && !PINS.down && count == ALL_ONES ##1 count == ZERO);

   c_down_wrap: cover property (step && PINS.down && count == ZERO ##1 count == ALL_ONES);

   c_load: cover property (loading ##1 !loading);

   c_ripple_pulse: cover property (PINS_OUT.ripple_n ##1 !PINS_OUT.ripple_n ##1 PINS_OUT.ripple_n);

   c_hold_blocks: cover property (hold && clk_rise && !loading);
endmodule

`default_nettype wire

/* dv/udc_ctl_model.sv */
// Control-logic model driving count clock, enable and direction of the counter
`timescale 1ns/1ps
`default_nettype none
module udc_ctl_model (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic step,
   input  wire logic want_en,
   input  wire logic want_down,
   output var  logic cclk,
   output var  logic en_n,
   output var  logic down
);
   // Count clock rests high; a step gives one low cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cclk <= 1'b1;
         en_n <= 1'b1;
         down <= 1'b0;
      end else begin
         cclk <= !(step && cclk);
         if (cclk && !step) begin
            en_n <= !want_en;
            down <= want_down;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Testbench for the up/down counter: pin stepping, load, hold and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "udc_regs.svh"
module tb_top;
   import udc_pkg::*;
   logic          clk_sys, reset_n, load_n, step, want_en, want_down, cclk, en_n, down;
   logic          pready, pslverr, irq, err, rip;
   logic [3:0]    preset;
   logic [31:0]   prdata, rd;
   udc_pins_in_t  pins;
   udc_pins_out_t pins_out, out2, out3;
   udc_pins_in_t  pins2, pins3;
   udc_apb_req_t  req;
   int            err_total, num_checks, cyc;
   assign pins = '{load_n, preset, en_n, down, cclk};
   udc_ctl_model i_ctl (.clk_sys(clk_sys), .rst_n(reset_n), .step(step), .want_en(want_en),
      .want_down(want_down), .cclk(cclk), .en_n(en_n), .down(down));
   udc_counter i_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .PINS(pins), .PINS_OUT(pins_out),
      .APB(req), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
   // Ripple stage clocked by the first stage's ripple clock
   assign pins2 = '{1'b1, 4'h0, 1'b0, down, pins_out.ripple_n};
   // Synchronous stage: terminal count only gates enable, never clocks
   assign pins3 = '{1'b1, 4'h0, en_n | !pins_out.tc, down, cclk};
   udc_counter i_dut2 (.CLK_SYS(clk_sys), .RESET_N(reset_n), .PINS(pins2), .PINS_OUT(out2),
      .APB('0), .PRDATA(), .PREADY(), .PSLVERR(), .IRQ());
   udc_counter i_dut3 (.CLK_SYS(clk_sys), .RESET_N(reset_n), .PINS(pins3), .PINS_OUT(out3),
      .APB('0), .PRDATA(), .PREADY(), .PSLVERR(), .IRQ());
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = !clk_sys;
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      req <= '0;
   endtask
   // One count clock step; ripple clock is sampled in the low phase
   task automatic pulse;
      @(posedge clk_sys);
      step <= 1'b1;
      @(posedge clk_sys);
      step <= 1'b0;
      @(posedge clk_sys);
      rip = pins_out.ripple_n;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic see(input logic [3:0] c, input logic t);
      chk("count", {28'h0, pins_out.count}, {28'h0, c});
      chk("tc", {31'h0, pins_out.tc}, {31'h0, t});
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      reset_n = 1'b0;
      load_n = 1'b1;
      preset = 4'h0;
      step = 1'b0;
      want_en = 1'b1;
      want_down = 1'b0;
      req = '0;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      apb(1'b0, `UDC_CTRL_OFS, 32'h0);
      chk("ctrl", rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", {31'h0, err}, 32'h1);
      see(4'h0, 1'b0);
      $display("test reset done");
      load_n <= 1'b0;
      preset <= 4'hE;
      @(posedge clk_sys);
      @(posedge clk_sys);
      see(4'hE, 1'b0);
      pulse();
      see(4'hE, 1'b0);
      load_n <= 1'b1;
      pulse();
      see(4'hF, 1'b1);
      want_en <= 1'b0;
      pulse();
      see(4'hF, 1'b1);
      chk("ripple off", {31'h0, rip}, 32'h1);
      want_en <= 1'b1;
      pulse();
      chk("ripple pulse", {31'h0, rip}, 32'h0);
      see(4'h0, 1'b0);
      chk("stage2", {28'h0, out2.count}, 32'h1);
      chk("stage3", {28'h0, out3.count}, 32'h1);
      $display("test load and count up done");
      apb(1'b0, `UDC_IRQ_STAT_OFS, 32'h0);
      chk("irq stat", rd, 32'h3);
      chk("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b1, `UDC_IRQ_MASK_OFS, 32'h1);
      @(posedge clk_sys);
      chk("irq raised", {31'h0, irq}, 32'h1);
      apb(1'b1, `UDC_IRQ_STAT_OFS, 32'h3);
      @(posedge clk_sys);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      $display("test interrupt done");
      want_down <= 1'b1;
      repeat (3) @(posedge clk_sys);
      see(4'h0, 1'b1);
      pulse();
      see(4'hF, 1'b0);
      chk("stage2 down", {28'h0, out2.count}, 32'h0);
      chk("stage3 down", {28'h0, out3.count}, 32'h0);
      apb(1'b1, `UDC_CTRL_OFS, 32'h1);
      pulse();
      see(4'hF, 1'b0);
      apb(1'b1, `UDC_CTRL_OFS, 32'h0);
      pulse();
      apb(1'b0, `UDC_STATUS_OFS, 32'h0);
      chk("status", rd, 32'h0002000E);
      $display("test count down and hold done");
      summarize();
   end
endmodule
`default_nettype wire
